//--- tb/pic_core_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Core model: machine-cycle pulse, return stack, exits
// ----------------------------------------------------------------
module pic_core_model #(
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Calls from the controller, requests from the bench
	input  wire logic       irq_call_in,
	input  wire logic [2:0] req_in,
	// Core signals towards the controller
	output logic            late_phase_pulse_out,
	output logic            stack_full_out,
	output logic            irq_exit_restore_out,
	output logic            subroutine_exit_plain_out
);
	logic [1:0] phase_ff;
	logic [4:0] depth_ff;

	// Full as a level so an interrupt call can never overrun the stack
	assign stack_full_out = (depth_ff == 5'(DEPTH));

	// One pulse per four clocks; stack pushes on calls, pops on exits
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_ff <= '0;
			depth_ff <= '0;
			late_phase_pulse_out <= 1'b0;
			irq_exit_restore_out <= 1'b0;
			subroutine_exit_plain_out <= 1'b0;
		end else begin
			phase_ff <= phase_ff + 2'd1;
			late_phase_pulse_out <= (phase_ff == 2'd2);
			subroutine_exit_plain_out <= req_in[0];
			irq_exit_restore_out <= req_in[1];
			depth_ff <= depth_ff + 5'(irq_call_in) + 5'(req_in[2]) - 5'(req_in[0]) - 5'(req_in[1]);
		end
	end
endmodule

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pic_cfg.svh"

// ----------------------------------------------------------------
// Bench for the prioritised interrupt controller
// ----------------------------------------------------------------
module tb;
	import pic_pkg::*;
	localparam pic_addr_t A0 = {`PIC_IDX_INTERRUPT_CONTROL_0, 2'b00};
	localparam pic_addr_t A1 = {`PIC_IDX_INTERRUPT_CONTROL_1, 2'b00};
	localparam pic_addr_t AM = {`PIC_IDX_SECONDARY_INTERRUPT_CONTROL, 2'b00};
	localparam pic_addr_t AS = {`PIC_IDX_EVT_STAT, 2'b00};
	localparam pic_addr_t AK = {`PIC_IDX_EVT_MASK, 2'b00};
	localparam pic_addr_t RA [5] = '{A0, A1, AM, AS, AK};
	logic        clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
	logic        ext0_pin, ext1_pin, slot1_adc, irq_call, in_service, irq, lpp, sfull, irq_exit_restore, ret;
	pic_addr_t   paddr;
	pic_word_t   pwdata, prdata;
	pic_byte_t   vec;
	logic [7:0]  evt;
	logic [2:0]  creq;
	pic_edge_t   edge0, edge1;
	logic        slot2_ser;
	logic [31:0] seed;
	int          error_cnt, n_compared;
	logic [32:0] rq[$];
	pic_byte_t   vq[$];

	// Clock
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	pic_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .ext0_pin_in(ext0_pin), .ext1_pin_in(ext1_pin),
		.cfg_ext0_edge_in(edge0), .cfg_ext1_edge_in(edge1), .cfg_slot1_adc_in(slot1_adc),
		.cfg_slot2_serial_in(slot2_ser), .adc_done_in(evt[0]), .serial_done_in(evt[1]),
		.timer0_ovf_in(evt[2]), .timer1_ovf_in(evt[3]), .uart_event_in(evt[4]),
		.timer2_ovf_in(evt[5]), .timebase_in(evt[6]), .rtc_in(evt[7]),
		.late_phase_pulse_in(lpp), .stack_full_in(sfull), .irq_exit_restore_in(irq_exit_restore),
		.subroutine_exit_plain_in(ret), .irq_call_out(irq_call), .irq_vector_out(vec),
		.in_service_out(in_service), .irq_out(irq));

	pic_core_model #(.DEPTH(2)) core_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.irq_call_in(irq_call), .req_in(creq), .late_phase_pulse_out(lpp),
		.stack_full_out(sfull), .irq_exit_restore_out(irq_exit_restore), .subroutine_exit_plain_out(ret));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Random edges on a pin that the serial option must ignore
	always @(posedge clk_in) begin
		seed <= xs(seed);
		ext1_pin <= seed[0];
	end

	task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// APB master; ends off the edge so later checks never race it
	task automatic apb(input logic w, input pic_addr_t a, input pic_word_t d);
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		// Ready is taken at the rising edge itself; only the watchdog ends a hang
		do @(posedge clk_in); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk_in);
	endtask

	task automatic wr(input pic_addr_t a, input pic_word_t d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input pic_addr_t a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, '0);
	endtask

	task automatic ev(input logic [7:0] m);
		@(posedge clk_in);
		evt <= m;
		@(posedge clk_in);
		evt <= 8'h00;
	endtask

	// Core request: 0 plain return, 1 interrupt return, 2 subroutine call
	task automatic core(input int b);
		@(posedge clk_in);
		creq[b] <= 1'b1;
		@(posedge clk_in);
		creq <= 3'b000;
	endtask

	task automatic idle(input int c);
		repeat (c) @(negedge clk_in);
	endtask

	task automatic wc;
		int n;
		n = 0;
		@(negedge clk_in);
		while (irq_call !== 1'b1 && n < 100) begin
			@(negedge clk_in);
			n++;
		end
		chk("call", irq_call, 1);
	endtask

	// Monitor: every read and every call takes the oldest note
	always @(negedge clk_in) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("read", {pslverr, prdata}, rq.size() ? rq.pop_front() : 'x);
		if (irq_call === 1'b1)
			chk("vector", 33'(vec), vq.size() ? 33'(vq.pop_front()) : 'x);
	end

	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#(20 * 20_000);
		error_cnt++;
		stop_test();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, evt, creq} = '0;
		edge0 = 2'b01;
		edge1 = 2'b11;
		slot2_ser = 1'b1;
		rst_n_in = 1'b0;
		ext0_pin = 1'b1;
		slot1_adc = 1'b1;
		seed = 32'h0000_e1a8;
		error_cnt = 0;
		n_compared = 0;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		// Reset values, unused bits, unmapped place
		foreach (RA[i]) rd(RA[i], '0);
		rd(8'h00, 33'h1_0000_0000);
		wr(AM, 32'h0000_00ff);
		rd(AM, 32'h0000_0077);
		wr(A1, 32'h0000_00ff);
		rd(A1, 32'h0000_0077);
		wr(A0, 32'h0000_007e);
		rd(A0, 32'h0000_007e);
		wr(AM, '0);
		wr(A1, '0);
		$display("register test done");
		// Six simultaneous requests, global enable off, then drained by priority
		wr(A0, 32'h0000_000e);
		wr(A1, 32'h0000_0007);
		ev(8'h3f);
		idle(16);
		rd(A0, 32'h0000_007e);
		rd(A1, 32'h0000_0077);
		vq.push_back(8'h04);
		// Flags written back as ones, so enabling does not wipe them
		wr(A0, 32'h0000_007f);
		for (int k = 0; k < 6; k++) begin
			wc();
			chk("in_service", in_service, 1);
			idle(12);
			if (k < 5) vq.push_back(8'h08 + 8'(4 * k));
			core(1);
		end
		idle(4);
		rd(AM, 32'h0000_0010);
		rd(A1, 32'h0000_0007);
		rd(A0, 32'h0000_000f);
		$display("priority test done");
		// Disabled source, plain return, nesting
		wr(A0, 32'h0000_0001);
		ev(8'h04);
		idle(12);
		rd(A0, 32'h0000_0041);
		vq.push_back(8'h0c);
		wr(A0, 32'h0000_0049);
		wc();
		core(0);
		idle(4);
		rd(A0, 32'h0000_0008);
		chk("in_service", in_service, 1);
		wr(A1, 32'h0000_0001);
		ev(8'h08);
		idle(12);
		vq.push_back(8'h10);
		wr(A0, 32'h0000_0009);
		wc();
		core(1);
		idle(4);
		chk("in_service", in_service, 0);
		$display("return test done");
		// Full stack holds back an enabled request
		core(2);
		core(2);
		ev(8'h08);
		idle(20);
		vq.push_back(8'h10);
		core(0);
		wc();
		core(1);
		core(0);
		$display("stack test done");
		// Event status, mask and summary line
		rd(AS, 32'h0000_003f);
		rd(AS, '0);
		wr(AK, 32'h0000_0080);
		ev(8'h80);
		idle(2);
		chk("irq", irq, 1);
		rd(AS, 32'h0000_0080);
		idle(2);
		chk("irq", irq, 0);
		ev(8'h40);
		idle(2);
		chk("irq", irq, 0);
		$display("event test done");
		// Falling edge on the first pin once it owns the first slot
		@(posedge clk_in);
		slot1_adc <= 1'b0;
		edge0 <= 2'b11;
		wr(A0, 32'h0000_0003);
		vq.push_back(8'h04);
		@(posedge clk_in);
		ext0_pin <= 1'b0;
		wc();
		core(1);
		// Serial moved to the shared fifth slot, second pin edges switched off
		@(posedge clk_in);
		slot2_ser <= 1'b0;
		edge1 <= 2'b00;
		wr(A1, 32'h0000_0002);
		vq.push_back(8'h14);
		ev(8'h02);
		wc();
		core(1);
		rd(AS, 32'h0000_0051);
		idle(8);
		chk("left over", 33'(vq.size() + rq.size()), 0);
		$display("pin test done");
		stop_test();
	end
endmodule

`default_nettype wire

//--- verilog/pic_cfg.svh
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PIC_IDX_INTERRUPT_CONTROL_0      6'h0b
`define PIC_IDX_INTERRUPT_CONTROL_1      6'h1e
`define PIC_IDX_SECONDARY_INTERRUPT_CONTROL       6'h2f
`define PIC_IDX_EVT_STAT   6'h30
`define PIC_IDX_EVT_MASK   6'h31

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIC_GIE_BIT        0
`define PIC_EN0_LO         1
`define PIC_EN_LO          0
`define PIC_FLAG_LO        4
`define PIC_MFF_BIT        6
`define PIC_SLOT_CNT       6
`define PIC_EVT_CNT        8

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PIC_CTRL_RST       7'h00
`define PIC_INTERRUPT_CONTROL_0_WMASK    7'h7f
`define PIC_CTRL_WMASK     7'h77
`define PIC_EVT_RST        8'h00

// ----------------------------------------------------------------
// Vector table: first vector, then one word step per slot
// ----------------------------------------------------------------
`define PIC_VEC_BASE       8'h04
`define PIC_VEC_RST        8'h00

// ----------------------------------------------------------------
// External edge select codes
// ----------------------------------------------------------------
`define PIC_EDGE_FALL_BIT  0
`define PIC_EDGE_RISE_BIT  1

`endif

//--- verilog/pic_pkg.sv
package pic_pkg;

	// Service state of the core seen by the controller
	typedef enum logic [0:0] {
		PIC_IDLE    = 1'b0,
		PIC_SERVICE = 1'b1
	} pic_svc_t;

	typedef logic [7:0]  pic_byte_t;
	typedef logic [31:0] pic_word_t;
	typedef logic [7:0]  pic_addr_t;
	typedef logic [5:0]  pic_slot_t;
	typedef logic [1:0]  pic_edge_t;

endpackage

//--- verilog/pic_prio.sv
`timescale 1ns/1ns
`default_nettype none

module pic_prio (
	// Pending requests, bit 0 is the highest priority
	input  wire logic [5:0]  pend_in,
	// One-hot winner and its slot number
	output logic      [5:0]  grant_out,
	output logic      [2:0]  slot_out,
	output logic             any_out
);

	// ----------------------------------------------------------------
	// Lowest set bit wins; losers simply stay pending
	// ----------------------------------------------------------------
	logic [6:0] lower;
	assign lower[0] = 1'b0;

	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_chain
			assign grant_out[i] = pend_in[i] & ~lower[i];
			assign lower[i+1]   = lower[i] | pend_in[i];
		end
	endgenerate

	// One-hot to binary
	always_comb begin
		slot_out = 3'h0;
		for (int k = 0; k < 6; k++) begin
			if (grant_out[k]) begin
				slot_out = 3'(k);
			end
		end
	end

	assign any_out = lower[6];

endmodule

`default_nettype wire

//--- verilog/pic_sync2.sv
`timescale 1ns/1ns
`default_nettype none

module pic_sync2 #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic          clk_in,
	input  wire logic          rst_n_in,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0]  async_in,
	output logic      [W-1:0]  sync_out
);

	// ----------------------------------------------------------------
	// Two flip-flops per bit; stage one feeds stage two only
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_ff;
			logic stab_ff;
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					meta_ff <= 1'b0;
					stab_ff <= 1'b0;
				end else begin
					meta_ff <= async_in[i];
					stab_ff <= meta_ff;
				end
			end
			assign sync_out[i] = stab_ff;
		end
	endgenerate

endmodule

`default_nettype wire

//--- verilog/pic_top.sv
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

`include "pic_cfg.svh"

// Notes on behaviour
// - Serial transfer sets flag; service clears flag, enable
// - In service, others held until exit or reenable
// - Return-from-interrupt sets global enable; plain return not
// - Requests sampled once per late-phase pulse
// - Fixed priority slots one to six, vectors 04-18
// - Global enable low blocks all servicing
// - Disabled source never serviced; flags stay set
// - Hardware never clears multi-function sub-flags
// - Second register enables bits 0-2; 3,7 zero
// - Second register flags in bits 4-6
// - Multi-function register enables 0-2, flags 4-6
// - Full stack blocks every acknowledge
// - Any sub-flag sets multi-function flag; ack clears it
// - First register: global, three enables, three flags
module pic_top (
	// Clock and reset
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	// APB slave
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire pic_pkg::pic_addr_t paddr_in,
	input  wire pic_pkg::pic_word_t pwdata_in,
	output pic_pkg::pic_word_t      prdata_out,
	output logic                    pready_out,
	output logic                    pslverr_out,
	// External pins and configuration options
	input  wire logic               ext0_pin_in,
	input  wire logic               ext1_pin_in,
	input  wire pic_pkg::pic_edge_t cfg_ext0_edge_in,
	input  wire pic_pkg::pic_edge_t cfg_ext1_edge_in,
	input  wire logic               cfg_slot1_adc_in,
	input  wire logic               cfg_slot2_serial_in,
	// Peripheral event pulses
	input  wire logic               adc_done_in,
	input  wire logic               serial_done_in,
	input  wire logic               timer0_ovf_in,
	input  wire logic               timer1_ovf_in,
	input  wire logic               uart_event_in,
	input  wire logic               timer2_ovf_in,
	input  wire logic               timebase_in,
	input  wire logic               rtc_in,
	// Processor core
	input  wire logic               late_phase_pulse_in,
	input  wire logic               stack_full_in,
	input  wire logic               irq_exit_restore_in,
	input  wire logic               subroutine_exit_plain_in,
	output logic                    irq_call_out,
	output pic_pkg::pic_byte_t      irq_vector_out,
	output logic                    in_service_out,
	// Summary interrupt
	output logic                    irq_out
);
	import pic_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [6:0]  interrupt_control_0_ff,  nxt_interrupt_control_0;
	logic [6:0]  interrupt_control_1_ff,  nxt_interrupt_control_1;
	logic [6:0]  secondary_interrupt_control_ff,   nxt_secondary_interrupt_control;
	logic [1:0]  ext_prev_ff, nxt_ext_prev;
	pic_byte_t   stat_ff,   nxt_stat;
	pic_byte_t   mask_ff,   nxt_mask;
	logic        irq_ff,    nxt_irq;
	pic_word_t   prdata_ff, nxt_prdata;
	logic        pready_ff, nxt_pready;
	logic        pslverr_ff, nxt_pslverr;
	logic        call_ff,   nxt_call;
	pic_byte_t   vector_ff, nxt_vector;
	pic_svc_t    svc_ff,    nxt_svc;

	logic [1:0]  ext_sync;
	logic [1:0]  ext_edge;
	logic [5:0]  pend, grant;
	logic [2:0]  slot;
	logic        any_pend, take;
	logic        set_s0, set_s1, set_s4, set_sub;
	pic_byte_t   evt;
	logic        setup, access, wr_acc, rd_acc;
	logic        hit0, hit1, hit2, hit_st, hit_mk, hit;

	// ----------------------------------------------------------------
	// Pin synchroniser and priority picker
	// ----------------------------------------------------------------
	pic_sync2 #(.W(2)) u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.async_in ({ext1_pin_in, ext0_pin_in}),
		.sync_out (ext_sync)
	);

	pic_prio u_prio (
		.pend_in   (pend),
		.grant_out (grant),
		.slot_out  (slot),
		.any_out   (any_pend)
	);

	// ----------------------------------------------------------------
	// Event decode
	// ----------------------------------------------------------------
	// Edge pick per pin; selector bits choose falling, rising or both
	assign ext_edge[0] = (ext_sync[0] & ~ext_prev_ff[0] & cfg_ext0_edge_in[`PIC_EDGE_RISE_BIT])
		| (~ext_sync[0] & ext_prev_ff[0] & cfg_ext0_edge_in[`PIC_EDGE_FALL_BIT]);
	assign ext_edge[1] = (ext_sync[1] & ~ext_prev_ff[1] & cfg_ext1_edge_in[`PIC_EDGE_RISE_BIT])
		| (~ext_sync[1] & ext_prev_ff[1] & cfg_ext1_edge_in[`PIC_EDGE_FALL_BIT]);
	// Shared slots: option chooses which source owns the vector
	assign set_s0  = cfg_slot1_adc_in ? adc_done_in : ext_edge[0];
	assign set_s1  = cfg_slot2_serial_in ? serial_done_in : ext_edge[1];
	assign set_s4  = uart_event_in | (~cfg_slot2_serial_in & serial_done_in);
	assign set_sub = timer2_ovf_in | timebase_in | rtc_in;
	assign evt     = {rtc_in, timebase_in, timer2_ovf_in, set_s4, timer1_ovf_in,
		timer0_ovf_in, set_s1, set_s0};

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	// Pending only where both flag and source enable are set
	assign pend = {interrupt_control_1_ff[6] & interrupt_control_1_ff[2], interrupt_control_1_ff[5] & interrupt_control_1_ff[1],
		interrupt_control_1_ff[4] & interrupt_control_1_ff[0], interrupt_control_0_ff[6] & interrupt_control_0_ff[3],
		interrupt_control_0_ff[5] & interrupt_control_0_ff[2], interrupt_control_0_ff[4] & interrupt_control_0_ff[1]};
	// Decide only on the sampling pulse; global enable and stack gate it
	assign take = late_phase_pulse_in & interrupt_control_0_ff[`PIC_GIE_BIT] & ~stack_full_in
		& any_pend;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign setup  = psel_in & ~penable_in;
	assign access = psel_in & penable_in & pready_ff;
	assign hit0   = paddr_in == {`PIC_IDX_INTERRUPT_CONTROL_0, 2'b00};
	assign hit1   = paddr_in == {`PIC_IDX_INTERRUPT_CONTROL_1, 2'b00};
	assign hit2   = paddr_in == {`PIC_IDX_SECONDARY_INTERRUPT_CONTROL, 2'b00};
	assign hit_st = paddr_in == {`PIC_IDX_EVT_STAT, 2'b00};
	assign hit_mk = paddr_in == {`PIC_IDX_EVT_MASK, 2'b00};
	assign hit    = hit0 | hit1 | hit2 | hit_st | hit_mk;
	assign wr_acc = access & pwrite_in & hit;
	assign rd_acc = access & ~pwrite_in & hit;

	// Zero-wait slave: ready in every access phase, error on a miss
	always_comb begin
		nxt_pready  = setup;
		nxt_pslverr = setup & ~hit;
		nxt_prdata  = prdata_ff;
		if (setup) begin
			nxt_prdata = 32'h0000_0000;
			if (hit0) begin
				nxt_prdata[6:0] = interrupt_control_0_ff;
			end
			if (hit1) begin
				nxt_prdata[6:0] = interrupt_control_1_ff;
			end
			if (hit2) begin
				nxt_prdata[6:0] = secondary_interrupt_control_ff;
			end
			if (hit_st) begin
				nxt_prdata[7:0] = stat_ff;
			end
			if (hit_mk) begin
				nxt_prdata[7:0] = mask_ff;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Control registers and request flags
	// ----------------------------------------------------------------
	// Order: software write, return restore, acknowledge, then sets win
	always_comb begin
		nxt_interrupt_control_0    = interrupt_control_0_ff;
		nxt_interrupt_control_1    = interrupt_control_1_ff;
		nxt_secondary_interrupt_control     = secondary_interrupt_control_ff;
		nxt_ext_prev = ext_sync;
		if (wr_acc & hit0) begin
			nxt_interrupt_control_0 = pwdata_in[6:0] & `PIC_INTERRUPT_CONTROL_0_WMASK;
		end
		if (wr_acc & hit1) begin
			nxt_interrupt_control_1 = pwdata_in[6:0] & `PIC_CTRL_WMASK;
		end
		if (wr_acc & hit2) begin
			nxt_secondary_interrupt_control = pwdata_in[6:0] & `PIC_CTRL_WMASK;
		end
		if (irq_exit_restore_in) begin
			nxt_interrupt_control_0[`PIC_GIE_BIT] = 1'b1;
		end
		if (take) begin
			// Clear only the winner; losers stay for later pulses
			nxt_interrupt_control_0[`PIC_GIE_BIT] = 1'b0;
			if (slot < 3'd3) begin
				nxt_interrupt_control_0[`PIC_FLAG_LO + 32'(slot)] = 1'b0;
			end else begin
				nxt_interrupt_control_1[`PIC_FLAG_LO + 32'(slot) - 3] = 1'b0;
			end
		end
		nxt_interrupt_control_0[6:4]             = nxt_interrupt_control_0[6:4] | {timer0_ovf_in, set_s1, set_s0};
		nxt_interrupt_control_1[5:4]             = nxt_interrupt_control_1[5:4] | {set_s4, timer1_ovf_in};
		nxt_interrupt_control_1[`PIC_MFF_BIT]    = nxt_interrupt_control_1[`PIC_MFF_BIT] | set_sub;
		nxt_secondary_interrupt_control[6:4]              = nxt_secondary_interrupt_control[6:4] | {rtc_in, timebase_in, timer2_ovf_in};
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			interrupt_control_0_ff    <= `PIC_CTRL_RST;
			interrupt_control_1_ff    <= `PIC_CTRL_RST;
			secondary_interrupt_control_ff     <= `PIC_CTRL_RST;
			ext_prev_ff <= 2'b00;
		end else begin
			interrupt_control_0_ff    <= nxt_interrupt_control_0;
			interrupt_control_1_ff    <= nxt_interrupt_control_1;
			secondary_interrupt_control_ff     <= nxt_secondary_interrupt_control;
			ext_prev_ff <= nxt_ext_prev;
		end
	end

	// ----------------------------------------------------------------
	// Call to the core and service state
	// ----------------------------------------------------------------
	// Nesting needs no extra path: reenabling global enable lets take through
	always_comb begin
		nxt_call   = take;
		nxt_vector = vector_ff;
		nxt_svc    = svc_ff;
		if (take) begin
			nxt_vector = `PIC_VEC_BASE + {3'b000, slot, 2'b00};
		end
		case (svc_ff)
			PIC_IDLE: begin
				if (take) begin
					nxt_svc = PIC_SERVICE;
				end
			end
			PIC_SERVICE: begin
				if (irq_exit_restore_in & ~take) begin
					nxt_svc = PIC_IDLE;
				end
			end
			default: begin
				nxt_svc = PIC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			call_ff   <= 1'b0;
			vector_ff <= `PIC_VEC_RST;
			svc_ff    <= PIC_IDLE;
		end else begin
			call_ff   <= nxt_call;
			vector_ff <= nxt_vector;
			svc_ff    <= nxt_svc;
		end
	end

	// ----------------------------------------------------------------
	// Event status, mask and summary interrupt
	// ----------------------------------------------------------------
	// Read clears only bits already returned, so a new event is never lost
	always_comb begin
		nxt_stat = stat_ff;
		nxt_mask = mask_ff;
		if (rd_acc & hit_st) begin
			nxt_stat = stat_ff & ~prdata_ff[7:0];
		end
		if (wr_acc & hit_mk) begin
			nxt_mask = pwdata_in[7:0];
		end
		nxt_stat = nxt_stat | evt;
		nxt_irq  = |(nxt_stat & mask_ff);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stat_ff <= `PIC_EVT_RST;
			mask_ff <= `PIC_EVT_RST;
			irq_ff  <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			irq_ff  <= nxt_irq;
		end
	end

	// Outputs straight from flip-flops
	assign prdata_out     = prdata_ff;
	assign pready_out     = pready_ff;
	assign pslverr_out    = pslverr_ff;
	assign irq_call_out   = call_ff;
	assign irq_vector_out = vector_ff;
	assign in_service_out = svc_ff;
	assign irq_out        = irq_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_take;
		take;
	endsequence
	sequence s_call_vec;
		call_ff && vector_ff == `PIC_VEC_BASE + {3'b000, $past(slot), 2'b00};
	endsequence

	a_call_vector: assert property (s_take |=> s_call_vec)
		else $error("call vector wrong");
	a_gie_block: assert property (!interrupt_control_0_ff[`PIC_GIE_BIT] |=> !call_ff)
		else $error("call while global enable low");
	a_stack_full: assert property (stack_full_in |=> !call_ff)
		else $error("call with full stack");
	a_sample_phase: assert property (call_ff |-> $past(late_phase_pulse_in))
		else $error("call off the sampling pulse");
	a_call_clr_gie: assert property (s_take |=> !interrupt_control_0_ff[`PIC_GIE_BIT])
		else $error("global enable not cleared on call");
	a_exit_sets: assert property (irq_exit_restore_in && !take |=> interrupt_control_0_ff[0])
		else $error("return did not restore enable");
	a_plain_ret: assert property (subroutine_exit_plain_in && !irq_exit_restore_in
		&& !take && !(wr_acc && hit0) |=> $stable(interrupt_control_0_ff[0]))
		else $error("plain return moved global enable");
	a_hold_svc: assert property (svc_ff == PIC_SERVICE && !interrupt_control_0_ff[0] |=> !call_ff)
		else $error("nested call without reenable");
	a_sub_kept: assert property ($fell(secondary_interrupt_control_ff[6:4] != 3'b000) |-> $past(wr_acc && hit2))
		else $error("sub-flag cleared by hardware");
	a_mff_follow: assert property (set_sub |=> interrupt_control_1_ff[`PIC_MFF_BIT])
		else $error("sub-flag did not raise summary flag");
	a_lose_stays: assert property (take && !wr_acc
		|=> ((interrupt_control_0_ff[6:4] & $past(pend[2:0] & ~grant[2:0])) == $past(pend[2:0] & ~grant[2:0])))
		else $error("losing request dropped");
	a_pend_enabled: assert property (take |-> (grant & pend) != 6'h00)
		else $error("disabled source serviced");
	a_rsvd_zero: assert property (pready_ff && (hit0 || hit1 || hit2)
		|-> prdata_ff[31:7] == 25'h0 && (hit0 || !prdata_ff[3]))
		else $error("reserved bit reads non-zero");
	// A set in the call cycle itself wins, so only a quiet source must read back clear
	a_flag_ack: assert property (s_take ##0 (slot == 3'd1 && !set_s1) |=> !interrupt_control_0_ff[5])
		else $error("serviced flag not cleared");

endmodule

`default_nettype wire
